// ### logic/icc_top.sv
// Pulse-width input capture channel with AXI4-Lite registers
`timescale 1ns/100ps
`default_nettype none
`include "icc_map.svh"
module icc_top import icc_pkg::*; (
    input wire logic i_clk,
    input wire logic i_rstn,
    input wire logic [15:0] i_src,
    input wire logic [7:0] i_awaddr,
    input wire logic i_awvalid,
    output logic o_awready,
    input wire logic [31:0] i_wdata,
    input wire logic [3:0] i_wstrb,
    input wire logic i_wvalid,
    output logic o_wready,
    output logic [1:0] o_bresp,
    output logic o_bvalid,
    input wire logic i_bready,
    input wire logic [7:0] i_araddr,
    input wire logic i_arvalid,
    output logic o_arready,
    output logic [31:0] o_rdata,
    output logic [1:0] o_rresp,
    output logic o_rvalid,
    input wire logic i_rready,
    output logic o_irq
);
    function automatic logic reg_hit(input logic [7:0] a);
        reg_hit = (a[1:0] == 2'h0) && (a <= `ICC_OFF_SRC);
    endfunction

    function automatic logic [31:0] strb_merge(input logic [31:0] o, input logic [31:0] n, input logic [3:0] s);
        logic [31:0] r;
        r = o;
        for (int i = 0; i < 4; i++) begin
            if (s[i]) begin
                r[i*8 +: 8] = n[i*8 +: 8];
            end
        end
        strb_merge = r;
    endfunction

    // Prescaled clock enables
    localparam icc_rate_t RATES [4] = '{`ICC_SRC0_KHZ, `ICC_SRC1_KHZ, `ICC_SRC2_KHZ, `ICC_SRC3_KHZ};
    logic [3:0] tick;
    genvar g;
    generate
        for (g = 0; g < 4; g++) begin : g_rate
            icc_tick_if u_if ();
            icc_rate_gen #(.INC(RATES[g])) u_gen (
                .i_clk(i_clk),
                .i_rstn(i_rstn),
                .o_tick(u_if)
            );
            assign tick[g] = u_if.tick;
        end
    endgenerate

    // Bus state
    logic aw_full_reg, aw_full_next, w_full_reg, w_full_next;
    logic [7:0] awaddr_reg, awaddr_next;
    logic [31:0] wdata_reg, wdata_next;
    logic [3:0] wstrb_reg, wstrb_next;
    logic awready_reg, awready_next, wready_reg, wready_next;
    logic bvalid_reg, bvalid_next, arready_reg, arready_next, rvalid_reg, rvalid_next;
    logic [1:0] bresp_reg, bresp_next, rresp_reg, rresp_next;
    logic [31:0] rdata_reg, rdata_next;
    logic do_wr, ar_take;

    // Software registers
    logic [31:0] ctrl_reg, ctrl_next;
    logic [5:0] flg_reg, flg_next, msk_reg, msk_next;
    logic mode_reg, mode_next, irq_reg, irq_next;
    logic [3:0] srcsel_reg, srcsel_next;
    logic chrst, flg_wr;
    logic [5:0] flg_clr;

    // Channel state
    logic [15:0] sync1_reg, sync2_reg;
    logic in_prev_reg, in_cur;
    icc_state_e st_reg, st_next;
    icc_cnt_t cnt_reg, cnt_next, shd_reg, shd_next, cap1_reg, cap1_next, cap2_reg, cap2_next;
    logic [5:0] ev;
    logic rise, fall, start_edge, stop_edge, run_ok, tick_sel, clr_en;

    // Bus handshakes: address and data may arrive in either order
    always_comb begin
        aw_full_next = aw_full_reg;
        w_full_next = w_full_reg;
        awaddr_next = awaddr_reg;
        wdata_next = wdata_reg;
        wstrb_next = wstrb_reg;
        bvalid_next = bvalid_reg;
        bresp_next = bresp_reg;
        // Read address is offered again once no response is pending
        arready_next = !rvalid_reg;
        rvalid_next = rvalid_reg;
        rdata_next = rdata_reg;
        rresp_next = rresp_reg;
        ar_take = i_arvalid && arready_reg;
        do_wr = aw_full_reg && w_full_reg && !bvalid_reg;
        if (i_awvalid && awready_reg) begin
            aw_full_next = 1'b1;
            awaddr_next = i_awaddr;
        end
        if (i_wvalid && wready_reg) begin
            w_full_next = 1'b1;
            wdata_next = i_wdata;
            wstrb_next = i_wstrb;
        end
        if (bvalid_reg && i_bready) begin
            bvalid_next = 1'b0;
        end
        if (do_wr) begin
            aw_full_next = 1'b0;
            w_full_next = 1'b0;
            bvalid_next = 1'b1;
            bresp_next = reg_hit(awaddr_reg) ? 2'h0 : 2'h2;
        end
        awready_next = !aw_full_next;
        wready_next = !w_full_next;
        if (rvalid_reg && i_rready) begin
            rvalid_next = 1'b0;
            arready_next = 1'b1;
        end
        if (ar_take) begin
            arready_next = 1'b0;
            rvalid_next = 1'b1;
            rresp_next = reg_hit(i_araddr) ? 2'h0 : 2'h2;
            case (i_araddr)
                `ICC_OFF_CTRL: rdata_next = ctrl_reg;
                `ICC_OFF_CNT: rdata_next = {8'h0, cnt_reg};
                `ICC_OFF_SHD: rdata_next = {8'h0, shd_reg};
                `ICC_OFF_CAP1: rdata_next = {8'h0, cap1_reg};
                `ICC_OFF_CAP2: rdata_next = {8'h0, cap2_reg};
                `ICC_OFF_FLG: rdata_next = {26'h0, flg_reg};
                `ICC_OFF_MSK: rdata_next = {26'h0, msk_reg};
                `ICC_OFF_MODE: rdata_next = {31'h0, mode_reg};
                `ICC_OFF_SRC: rdata_next = {28'h0, srcsel_reg};
                // Extended and timeout registers hold their reset value
                default: rdata_next = `ICC_ZERO_RESET;
            endcase
        end
    end

    always_ff @(posedge i_clk) begin
        if (!i_rstn) begin
            aw_full_reg <= 1'b0;
            w_full_reg <= 1'b0;
            awaddr_reg <= 8'h0;
            wdata_reg <= 32'h0;
            wstrb_reg <= 4'h0;
            awready_reg <= 1'b0;
            wready_reg <= 1'b0;
            bvalid_reg <= 1'b0;
            bresp_reg <= 2'h0;
            arready_reg <= 1'b0;
            rvalid_reg <= 1'b0;
            rdata_reg <= 32'h0;
            rresp_reg <= 2'h0;
        end else begin
            aw_full_reg <= aw_full_next;
            w_full_reg <= w_full_next;
            awaddr_reg <= awaddr_next;
            wdata_reg <= wdata_next;
            wstrb_reg <= wstrb_next;
            awready_reg <= awready_next;
            wready_reg <= wready_next;
            bvalid_reg <= bvalid_next;
            bresp_reg <= bresp_next;
            arready_reg <= arready_next;
            rvalid_reg <= rvalid_next;
            rdata_reg <= rdata_next;
            rresp_reg <= rresp_next;
        end
    end

    // Register writes and interrupt flags
    always_comb begin
        ctrl_next = ctrl_reg;
        msk_next = msk_reg;
        mode_next = mode_reg;
        srcsel_next = srcsel_reg;
        chrst = 1'b0;
        flg_wr = do_wr && (awaddr_reg == `ICC_OFF_FLG);
        flg_clr = 6'h0;
        if (do_wr) begin
            case (awaddr_reg)
                `ICC_OFF_RST: chrst = wstrb_reg[0] && wdata_reg[`ICC_RST_CH_BIT];
                `ICC_OFF_CTRL: ctrl_next = strb_merge(ctrl_reg, wdata_reg, wstrb_reg) & `ICC_CTRL_MASK;
                `ICC_OFF_FLG: flg_clr = wstrb_reg[0] ? wdata_reg[5:0] : 6'h0;
                `ICC_OFF_MSK: msk_next = wstrb_reg[0] ? wdata_reg[5:0] : msk_reg;
                `ICC_OFF_MODE: mode_next = wstrb_reg[0] ? wdata_reg[0] : mode_reg;
                `ICC_OFF_SRC: srcsel_next = wstrb_reg[0] ? wdata_reg[3:0] : srcsel_reg;
                default: chrst = 1'b0;
            endcase
        end
        // One-shot end of measurement drops the enable
        if (clr_en) begin
            ctrl_next[`ICC_CTRL_EN] = 1'b0;
        end
        // Event in the clearing cycle survives the clear
        flg_next = (flg_reg & ~flg_clr) | ev;
        if (chrst) begin
            flg_next = 6'h0;
        end
        // Level mode follows the gated flags, pulse mode marks new gated events
        irq_next = mode_reg ? |(ev & msk_reg) : |(flg_reg & msk_reg);
    end

    always_ff @(posedge i_clk) begin
        if (!i_rstn) begin
            ctrl_reg <= `ICC_CTRL_RESET;
            flg_reg <= 6'h0;
            msk_reg <= 6'h0;
            mode_reg <= 1'b0;
            srcsel_reg <= 4'h0;
            irq_reg <= 1'b0;
        end else begin
            ctrl_reg <= ctrl_next;
            flg_reg <= flg_next;
            msk_reg <= msk_next;
            mode_reg <= mode_next;
            srcsel_reg <= srcsel_next;
            irq_reg <= irq_next;
        end
    end

    // Only the second stage feeds the selector; edges are seen on every i_clk cycle, not only on the prescaled tick
    always_ff @(posedge i_clk) begin
        if (!i_rstn) begin
            sync1_reg <= 16'h0;
            sync2_reg <= 16'h0;
            in_prev_reg <= 1'b0;
        end else begin
            sync1_reg <= i_src;
            sync2_reg <= sync1_reg;
            in_prev_reg <= in_cur;
        end
    end

    // Pulse-width measurement channel
    always_comb begin
        in_cur = sync2_reg[srcsel_reg];
        rise = in_cur && !in_prev_reg;
        fall = !in_cur && in_prev_reg;
        start_edge = ctrl_reg[`ICC_CTRL_RISE] ? rise : fall;
        stop_edge = ctrl_reg[`ICC_CTRL_RISE] ? fall : rise;
        run_ok = ctrl_reg[`ICC_CTRL_EN] && (ctrl_reg[`ICC_CTRL_MODE_HI:`ICC_CTRL_MODE_LO] == `ICC_MODE_PWIDTH);
        tick_sel = tick[ctrl_reg[`ICC_CTRL_CLK_HI:`ICC_CTRL_CLK_LO]];
        st_next = st_reg;
        cnt_next = cnt_reg;
        shd_next = shd_reg;
        cap1_next = cap1_reg;
        cap2_next = cap2_reg;
        ev = 6'h0;
        clr_en = 1'b0;
        case (st_reg)
            ICC_OFF: begin
                if (run_ok) begin
                    st_next = ICC_WAIT;
                end
            end
            ICC_WAIT: begin
                if (!run_ok) begin
                    st_next = ICC_OFF;
                end else if (start_edge && ctrl_reg[`ICC_CTRL_CNT_EN]) begin
                    cnt_next = '0;
                    st_next = ICC_RUN;
                    ev[`ICC_FLG_START] = 1'b1;
                end
            end
            ICC_RUN: begin
                if (!run_ok) begin
                    st_next = ICC_OFF;
                end else begin
                    if (tick_sel && ctrl_reg[`ICC_CTRL_CNT_EN]) begin
                        cnt_next = cnt_reg + 24'h1;
                        ev[`ICC_FLG_OVF] = &cnt_reg;
                    end
                    if (stop_edge && ctrl_reg[`ICC_CTRL_SHD_EN]) begin
                        shd_next = cnt_reg;
                        ev[`ICC_FLG_SHD] = 1'b1;
                    end
                    // Both transfers and the restart land on the same edge
                    if (start_edge) begin
                        if (ctrl_reg[`ICC_CTRL_CAP_EN]) begin
                            cap1_next = ctrl_reg[`ICC_CTRL_SEL1] ? shd_reg : cnt_reg;
                            cap2_next = ctrl_reg[`ICC_CTRL_SEL2] ? cnt_reg : shd_reg;
                            ev[`ICC_FLG_CAP] = 1'b1;
                            ev[`ICC_FLG_OVWR] = flg_reg[`ICC_FLG_CAP];
                        end
                        cnt_next = '0;
                        if (ctrl_reg[`ICC_CTRL_ONESHOT]) begin
                            st_next = ICC_OFF;
                            clr_en = 1'b1;
                        end else begin
                            st_next = ICC_RUN;
                        end
                    end
                end
            end
            default: st_next = ICC_OFF;
        endcase
        if (chrst) begin
            st_next = ICC_OFF;
            cnt_next = '0;
            shd_next = '0;
            cap1_next = '0;
            cap2_next = '0;
            ev = 6'h0;
            clr_en = 1'b0;
        end
    end

    always_ff @(posedge i_clk) begin
        if (!i_rstn) begin
            st_reg <= ICC_OFF;
            cnt_reg <= '0;
            shd_reg <= '0;
            cap1_reg <= '0;
            cap2_reg <= '0;
        end else begin
            st_reg <= st_next;
            cnt_reg <= cnt_next;
            shd_reg <= shd_next;
            cap1_reg <= cap1_next;
            cap2_reg <= cap2_next;
        end
    end

    assign o_awready = awready_reg;
    assign o_wready = wready_reg;
    assign o_bvalid = bvalid_reg;
    assign o_bresp = bresp_reg;
    assign o_arready = arready_reg;
    assign o_rvalid = rvalid_reg;
    assign o_rdata = rdata_reg;
    assign o_rresp = rresp_reg;
    assign o_irq = irq_reg;

    default clocking cb @(posedge i_clk);
    endclocking
    default disable iff (!i_rstn);

    chk_soft_rst_clears:
    assert property (chrst |=> (st_reg == ICC_OFF) && (cnt_reg == '0) && (cap2_reg == '0)) else $error("soft reset missed");
    chk_count_on_tick:
    assert property ((st_reg == ICC_RUN) && run_ok && !start_edge && tick_sel && ctrl_reg[`ICC_CTRL_CNT_EN] && !chrst
        |=> cnt_reg == $past(cnt_reg) + 24'h1) else $error("counter did not advance");
    chk_start_edge:
    assert property ((st_reg == ICC_WAIT) && run_ok && start_edge && ctrl_reg[`ICC_CTRL_CNT_EN] && !chrst
        |=> (st_reg == ICC_RUN) && (cnt_reg == '0)) else $error("start edge ignored");
    chk_second_capture:
    assert property ((st_reg == ICC_RUN) && run_ok && start_edge && ctrl_reg[`ICC_CTRL_CAP_EN]
        && ctrl_reg[`ICC_CTRL_SEL2] && !chrst |=> cap2_reg == $past(cnt_reg) && cnt_reg == '0) else $error("second capture wrong");
    chk_first_capture:
    assert property ((st_reg == ICC_RUN) && run_ok && start_edge && ctrl_reg[`ICC_CTRL_CAP_EN]
        && ctrl_reg[`ICC_CTRL_SEL1] && !chrst |=> cap1_reg == $past(shd_reg)) else $error("first capture wrong");
    chk_continuous_rearm:
    assert property ((st_reg == ICC_RUN) && run_ok && start_edge && !ctrl_reg[`ICC_CTRL_ONESHOT] && !chrst
        |=> st_reg == ICC_RUN) else $error("channel stopped in continuous mode");
    chk_flag_clear_all:
    assert property (flg_wr && wstrb_reg[0] && (wdata_reg[5:0] == `ICC_FLG_ALL) && (ev == 6'h0)
        |=> flg_reg == 6'h0) else $error("flags not cleared");
    chk_irq_masked:
    assert property ((msk_reg == 6'h0) [*2] |-> !o_irq) else $error("interrupt with zero mask");
    chk_irq_level:
    assert property ((!mode_reg && |(flg_reg & msk_reg)) [*2] |-> o_irq) else $error("level interrupt dropped");
    chk_ext_reads_zero:
    assert property (ar_take && (i_araddr inside {`ICC_OFF_ECTRL, `ICC_OFF_TOTHR, `ICC_OFF_TOCNT})
        |=> o_rvalid && (o_rdata == 32'h0)) else $error("extended register not zero");
    chk_shadow_fall:
    assert property ((st_reg == ICC_RUN) && run_ok && stop_edge && ctrl_reg[`ICC_CTRL_SHD_EN] && !chrst
        |=> shd_reg == $past(cnt_reg)) else $error("shadow not loaded");
endmodule
`default_nettype wire

// ### shared/icc_map.svh
// Register offsets, field positions, reset values and rates of the capture channel
`ifndef ICC_MAP_SVH
`define ICC_MAP_SVH
`define ICC_OFF_RST 8'h00
`define ICC_OFF_CTRL 8'h04
`define ICC_OFF_ECTRL 8'h08
`define ICC_OFF_TOTHR 8'h0c
`define ICC_OFF_TOCNT 8'h10
`define ICC_OFF_CNT 8'h14
`define ICC_OFF_SHD 8'h18
`define ICC_OFF_CAP1 8'h1c
`define ICC_OFF_CAP2 8'h20
`define ICC_OFF_FLG 8'h24
`define ICC_OFF_MSK 8'h28
`define ICC_OFF_MODE 8'h2c
`define ICC_OFF_SRC 8'h30
`define ICC_RST_CH_BIT 2
`define ICC_CTRL_EN 0
`define ICC_CTRL_MODE_HI 3
`define ICC_CTRL_MODE_LO 1
`define ICC_MODE_PWIDTH 3'h0
`define ICC_CTRL_ONESHOT 4
`define ICC_CTRL_CNT_EN 8
`define ICC_CTRL_SHD_EN 9
`define ICC_CTRL_CAP_EN 10
`define ICC_CTRL_RISE 11
`define ICC_CTRL_SEL2 13
`define ICC_CTRL_SEL1 14
`define ICC_CTRL_CLK_HI 25
`define ICC_CTRL_CLK_LO 24
`define ICC_CTRL_MASK 32'h0300_6f1f
`define ICC_CTRL_RESET 32'h0000_0000
`define ICC_FLG_CAP 0
`define ICC_FLG_SHD 1
`define ICC_FLG_OVF 2
`define ICC_FLG_START 3
`define ICC_FLG_TOUT 4
`define ICC_FLG_OVWR 5
`define ICC_FLG_ALL 6'h3f
`define ICC_ZERO_RESET 32'h0000_0000
`define ICC_CLK_KHZ 17'd100000
`define ICC_SRC0_KHZ 17'd80000
`define ICC_SRC1_KHZ 17'd10000
`define ICC_SRC2_KHZ 17'd1000
`define ICC_SRC3_KHZ 17'd100
`endif

// ### shared/icc_pkg.sv
// Types shared by the capture channel modules
package icc_pkg;
    typedef enum logic [2:0] {
        ICC_OFF = 3'b001,
        ICC_WAIT = 3'b010,
        ICC_RUN = 3'b100
    } icc_state_e;
    typedef logic [23:0] icc_cnt_t;
    typedef logic [16:0] icc_rate_t;
endpackage

// ### shared/icc_tick_if.sv
// Prescaled clock enable between rate generator and channel
`timescale 1ns/100ps
`default_nettype none
interface icc_tick_if;
    logic tick;
    modport gen (output tick);
    modport dst (input tick);
endinterface
`default_nettype wire

// ### logic/icc_rate_gen.sv
// Fractional-rate clock enable generator
`timescale 1ns/100ps
`default_nettype none
`include "icc_map.svh"
module icc_rate_gen import icc_pkg::*; #(
    parameter icc_rate_t INC = 17'd1
) (
    input wire logic i_clk,
    input wire logic i_rstn,
    icc_tick_if.gen o_tick
);
    icc_rate_t acc_reg;
    icc_rate_t acc_next;
    logic tick_reg;
    logic tick_next;
    logic [17:0] sum;

    // Accumulator wraps at the main rate, so non-integer ratios stay exact on average
    always_comb begin
        sum = {1'b0, acc_reg} + {1'b0, INC};
        acc_next = sum[16:0];
        tick_next = 1'b0;
        if (sum >= {1'b0, `ICC_CLK_KHZ}) begin
            acc_next = 17'(sum - {1'b0, `ICC_CLK_KHZ});
            tick_next = 1'b1;
        end
    end

    always_ff @(posedge i_clk) begin
        if (!i_rstn) begin
            acc_reg <= 17'h0;
            tick_reg <= 1'b0;
        end else begin
            acc_reg <= acc_next;
            tick_reg <= tick_next;
        end
    end

    assign o_tick.tick = tick_reg;
endmodule
`default_nettype wire

// ### tb/icc_wave_model.sv
// Square-wave phase source standing in for the motor-control output
`timescale 1ns/100ps
`default_nettype none
module icc_wave_model (
    input wire logic i_clk,
    input wire logic i_en,
    input wire logic [15:0] i_hi_cycles,
    input wire logic [15:0] i_lo_cycles,
    output logic o_phase_w
);
    logic [15:0] cnt_reg;
    // Idles low so each enable opens with a clean rising edge
    always_ff @(posedge i_clk) begin
        if (!i_en) begin
            cnt_reg <= 16'h0000;
            o_phase_w <= 1'b0;
        end else begin
            o_phase_w <= (cnt_reg < i_hi_cycles);
            cnt_reg <= (cnt_reg == i_hi_cycles + i_lo_cycles - 16'h0001) ? 16'h0000 : cnt_reg + 16'h0001;
        end
    end
endmodule
`default_nettype wire

// ### tb/testbench.sv
// Self-checking bench for the pulse-width capture channel
`timescale 1ns/100ps
`default_nettype none
`include "icc_map.svh"
module testbench;
    localparam int HI = 200;
    localparam int LO = 100;
    logic i_clk = 1'b0;
    logic i_rstn = 1'b0;
    logic [7:0] awaddr = 8'h00;
    logic awvalid = 1'b0;
    logic [31:0] wdata = 32'h0000_0000;
    logic wvalid = 1'b0;
    logic bready = 1'b0;
    logic [7:0] araddr = 8'h00;
    logic arvalid = 1'b0;
    logic rready = 1'b0;
    logic wave_en = 1'b0;
    logic wave;
    logic [15:0] src_bus;
    logic o_awready, o_wready, o_bvalid, o_arready, o_rvalid, o_irq;
    logic [1:0] o_bresp, o_rresp;
    logic [31:0] o_rdata;
    int n_fail = 0;
    int samples_checked = 0;

    // Phase output placed on source index five
    assign src_bus = {10'h000, wave, 5'h00};
    always #5 i_clk = ~i_clk;

    icc_wave_model phase_src (.i_clk(i_clk), .i_en(wave_en), .i_hi_cycles(16'(HI)),
        .i_lo_cycles(16'(LO)), .o_phase_w(wave));

    icc_top uut (.i_clk(i_clk), .i_rstn(i_rstn), .i_src(src_bus), .i_awaddr(awaddr),
        .i_awvalid(awvalid), .o_awready(o_awready), .i_wdata(wdata), .i_wstrb(4'hf),
        .i_wvalid(wvalid), .o_wready(o_wready), .o_bresp(o_bresp), .o_bvalid(o_bvalid),
        .i_bready(bready), .i_araddr(araddr), .i_arvalid(arvalid), .o_arready(o_arready),
        .o_rdata(o_rdata), .o_rresp(o_rresp), .o_rvalid(o_rvalid), .i_rready(rready),
        .o_irq(o_irq));

    task automatic tally_and_finish();
        if (n_fail == 0 && samples_checked > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask

    task automatic hang();
        n_fail++;
        $display("ERROR t=%0t wait limit reached", $time);
        tally_and_finish();
    endtask

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            n_fail++;
            $display("ERROR t=%0t seen %h expected %h", $time, seen, exp);
        end
    endtask

    function automatic logic [31:0] in_range(input logic [31:0] v, input int lo, input int hi);
        return (v >= lo && v <= hi) ? 32'h1 : 32'h0;
    endfunction

    task automatic axi_write(input logic [7:0] addr, input logic [31:0] data, input logic [1:0] exp_resp);
        logic a_done, w_done, a_ok, w_ok, got;
        logic [1:0] resp;
        int n;
        a_done = 1'b0;
        w_done = 1'b0;
        got = 1'b0;
        resp = 2'b00;
        awaddr <= addr;
        wdata <= data;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        for (n = 0; n < 1000 && !(a_done && w_done); n++) begin
            @(negedge i_clk);
            a_ok = !a_done && o_awready;
            w_ok = !w_done && o_wready;
            @(posedge i_clk);
            if (a_ok) begin
                awvalid <= 1'b0;
                a_done = 1'b1;
            end
            if (w_ok) begin
                wvalid <= 1'b0;
                w_done = 1'b1;
            end
        end
        if (!(a_done && w_done)) hang();
        bready <= 1'b1;
        for (n = 0; n < 1000 && !got; n++) begin
            @(negedge i_clk);
            got = o_bvalid;
            resp = o_bresp;
            @(posedge i_clk);
        end
        bready <= 1'b0;
        if (!got) hang();
        check({30'h0, resp}, {30'h0, exp_resp});
    endtask

    task automatic axi_read(input logic [7:0] addr, output logic [31:0] data, input logic [1:0] exp_resp);
        logic got;
        logic [1:0] resp;
        int n;
        got = 1'b0;
        resp = 2'b00;
        data = 32'h0;
        araddr <= addr;
        arvalid <= 1'b1;
        for (n = 0; n < 1000 && !got; n++) begin
            @(negedge i_clk);
            got = o_arready;
            @(posedge i_clk);
        end
        arvalid <= 1'b0;
        rready <= 1'b1;
        if (!got) hang();
        got = 1'b0;
        for (n = 0; n < 1000 && !got; n++) begin
            @(negedge i_clk);
            got = o_rvalid;
            data = o_rdata;
            resp = o_rresp;
            @(posedge i_clk);
        end
        rready <= 1'b0;
        if (!got) hang();
        check({30'h0, resp}, {30'h0, exp_resp});
    endtask

    task automatic read_expect(input logic [7:0] addr, input logic [31:0] exp);
        logic [31:0] v;
        axi_read(addr, v, 2'b00);
        check(v, exp);
    endtask

    // Polls the flags; bounded so a dead channel cannot stall the run
    task automatic wait_capture(output logic [31:0] flg);
        int n;
        flg = 32'h0;
        for (n = 0; n < 400 && flg[0] !== 1'b1; n++) axi_read(`ICC_OFF_FLG, flg, 2'b00);
        if (flg[0] !== 1'b1) hang();
    endtask

    task automatic scn_registers();
        logic [7:0] zr [3] = '{`ICC_OFF_ECTRL, `ICC_OFF_TOTHR, `ICC_OFF_TOCNT};
        logic [31:0] v;
        read_expect(`ICC_OFF_CTRL, `ICC_CTRL_RESET);
        foreach (zr[i]) begin
            axi_write(zr[i], 32'hffff_ffff, 2'b00);
            read_expect(zr[i], `ICC_ZERO_RESET);
        end
        axi_write(8'h40, 32'h0000_0001, 2'b10);
        axi_read(8'h40, v, 2'b10);
        check(v, 32'h0);
        axi_write(`ICC_OFF_SRC, 32'h0000_0005, 2'b00);
        axi_write(`ICC_OFF_MODE, 32'h0000_0000, 2'b00);
        axi_write(`ICC_OFF_MSK, 32'h0000_0000, 2'b00);
        axi_write(`ICC_OFF_CTRL, 32'h0000_6f01, 2'b00);
        read_expect(`ICC_OFF_CTRL, 32'h0000_6f01);
        axi_write(`ICC_OFF_FLG, 32'h0000_003f, 2'b00);
        read_expect(`ICC_OFF_FLG, 32'h0);
    endtask

    // Tolerance covers the irregular spacing of the fractional ticks
    task automatic scn_measure();
        logic [31:0] v;
        wave_en <= 1'b1;
        wait_capture(v);
        check(v & 32'h3f, 32'h0b);
        @(negedge i_clk);
        check({31'h0, o_irq}, 32'h0);
        @(posedge i_clk);
        axi_read(`ICC_OFF_CAP1, v, 2'b00);
        check(in_range(v, HI * 4 / 5 - 4, HI * 4 / 5 + 4), 32'h1);
        axi_read(`ICC_OFF_CAP2, v, 2'b00);
        check(in_range(v, (HI + LO) * 4 / 5 - 4, (HI + LO) * 4 / 5 + 4), 32'h1);
        axi_write(`ICC_OFF_FLG, 32'h0000_003f, 2'b00);
        read_expect(`ICC_OFF_FLG, 32'h0);
        wait_capture(v);
        check(v & 32'h3, 32'h3);
    endtask

    task automatic scn_irq();
        axi_write(`ICC_OFF_MSK, 32'h0000_0001, 2'b00);
        repeat (3) @(posedge i_clk);
        @(negedge i_clk);
        check({31'h0, o_irq}, 32'h1);
        @(posedge i_clk);
        wave_en <= 1'b0;
        repeat (20) @(posedge i_clk);
        @(negedge i_clk);
        check({31'h0, o_irq}, 32'h1);
        @(posedge i_clk);
        axi_write(`ICC_OFF_FLG, 32'h0000_003f, 2'b00);
        repeat (3) @(posedge i_clk);
        @(negedge i_clk);
        check({31'h0, o_irq}, 32'h0);
        @(posedge i_clk);
        axi_write(`ICC_OFF_MSK, 32'h0000_0000, 2'b00);
    endtask

    task automatic scn_soft_reset();
        logic [7:0] cr [4] = '{`ICC_OFF_SHD, `ICC_OFF_CAP1, `ICC_OFF_CAP2, `ICC_OFF_FLG};
        wave_en <= 1'b1;
        repeat (250) @(posedge i_clk);
        wave_en <= 1'b0;
        axi_write(`ICC_OFF_RST, 32'h0000_0004, 2'b00);
        repeat (2) @(posedge i_clk);
        foreach (cr[i]) read_expect(cr[i], 32'h0);
        read_expect(`ICC_OFF_CTRL, 32'h0000_6f01);
    endtask

    task automatic scn_source();
        logic [31:0] v;
        wave_en <= 1'b0;
        axi_write(`ICC_OFF_SRC, 32'h0000_0006, 2'b00);
        axi_write(`ICC_OFF_FLG, 32'h0000_003f, 2'b00);
        wave_en <= 1'b1;
        repeat (700) @(posedge i_clk);
        read_expect(`ICC_OFF_FLG, 32'h0);
        // Back on index five the phase must reach the channel again
        axi_write(`ICC_OFF_SRC, 32'h0000_0005, 2'b00);
        wait_capture(v);
        check(v & 32'h1, 32'h1);
        wave_en <= 1'b0;
    endtask

    initial begin
        repeat (20) @(posedge i_clk);
        i_rstn <= 1'b1;
        @(posedge i_clk);
        scn_registers();
        scn_measure();
        scn_irq();
        scn_soft_reset();
        scn_measure();
        scn_source();
        tally_and_finish();
    end
endmodule
`default_nettype wire
